/* File: core/chc_pkg.sv */
/*
 Package for the card host controller: modes, operations, states, timing counts.
 Assumes a 200 MHz system clock.
*/
package chc_pkg;
   localparam int CLK_MHZ = 200;
   // Strobe width and setup in nanoseconds.
   localparam int STROBE_NS = 80;
   localparam int SETUP_NS = 30;
   localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
   // Reset pulse to the card.
   localparam int RESET_NS = 1000;
   localparam int RESET_CYC = (RESET_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

   typedef enum logic [1:0] {
      CHC_MODE_MEM = 2'b00,
      CHC_MODE_IO = 2'b01,
      CHC_MODE_IDE = 2'b10
   } chc_mode_type;

   typedef enum logic [1:0] {
      CHC_OP_READ = 2'b00,
      CHC_OP_WRITE = 2'b01
   } chc_op_type;

   typedef enum logic [2:0] {
      CHC_ST_RESET = 3'b000,
      CHC_ST_WAITRDY = 3'b001,
      CHC_ST_IDLE = 3'b010,
      CHC_ST_SETUP = 3'b011,
      CHC_ST_STROBE = 3'b100,
      CHC_ST_DMA = 3'b101
   } chc_state_type;
endpackage : chc_pkg

/* File: core/chc_host.sv */
/*
 Host-side controller for the card's parallel port control signals.
 Assumes the card pins are wired directly; card outputs are asynchronous.
*/
// Notes on behaviour
// RULE1 - In IDE mode a grounded role select makes the card master.
// RULE2 - In IDE mode an open role select makes the card slave.
// RULE3 - In card bus modes host ties role select to A25 or ground.
// RULE4 - Memory mode card ignores the I/O write strobe.
// RULE5 - I/O mode card captures data on the write strobe's rising edge.
// RULE6 - IDE mode without burst treats write strobe like I/O mode.
// RULE7 - Host negates I/O write strobe before starting a fast-DMA burst.
// RULE8 - During a burst, asserting the write strobe line stops it.
// RULE9 - Memory mode reads use output enable, common and attribute space.
// RULE10 - I/O mode output enable only reads card info and configuration.
// RULE11 - Host grounds the IDE select input for IDE operation.
// RULE12 - Memory mode ready is high when free, low when busy.
// RULE13 - Ready stays low until power-up or reset sequence ends.
// RULE14 - Host makes no access while ready is low after reset.
// RULE15 - Reset held from power-up must not keep card busy forever.
// RULE16 - I/O mode interrupt is a low pulse or low level.
// RULE17 - IDE mode interrupt is active high.
// RULE18 - Space select high for common memory, low for attribute.
// RULE19 - Space select low during I/O cycles.
// RULE20 - Host asserts DMA acknowledge answering a DMA request.
// RULE21 - Card ignores DMA acknowledge when no DMA is active.
// RULE22 - IDE host without DMA drives DMA acknowledge high.
// RULE23 - Chip selects negated while DMA acknowledge asserted; 16-bit transfers.
// RULE24 - Card bus reset high; IDE reset low.
// RULE25 - Card samples IDE select at power-up and keeps the mode; the card model instead samples it at each card reset after power-up.
`timescale 1ns/1ps
`default_nettype none
module chc_host (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_reset_n,
   // User control.
   input wire logic [1:0] i_mode,
   input wire logic i_role_master,
   input wire logic i_dma_enable,
   input wire logic i_card_reset,
   input wire logic i_req_valid,
   input wire logic i_req_write,
   input wire logic i_req_attr,
   input wire logic i_burst_stop,
   input wire logic i_a25,
   output logic o_req_ready,
   output logic o_done,
   output logic o_card_busy,
   output logic o_irq,
   output logic o_dma_active,
   // Card pins.
   input wire logic i_card_ready,
   input wire logic i_card_interrupt_request,
   input wire logic i_dma_request_line,
   output logic o_card_reset_pin,
   output logic o_ide_mode_select_n,
   output logic o_drive_role_select_n,
   output logic o_drive_role_select_oe,
   output logic o_io_write_strobe_n,
   output logic o_output_enable_n,
   output logic o_write_enable_n,
   output logic o_space_select_n,
   output logic o_dma_acknowledge_n,
   output logic o_taskfile_chip_select_n,
   output logic o_control_block_chip_select_n
);
   // Three-stage synchronisers for card outputs.
   logic [2:0] rdy_sync_ff, nxt_rdy_sync;
   logic [2:0] irq_sync_ff, nxt_irq_sync;
   logic [2:0] drq_sync_ff, nxt_drq_sync;
   logic rdy_ff, nxt_rdy, irq_ff, nxt_irq, drq_ff, nxt_drq;
   // Controller state.
   chc_pkg::chc_state_type state_ff, nxt_state;
   logic [chc_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
   logic wr_ff, nxt_wr, attr_ff, nxt_attr, done_ff, nxt_done;
   logic [1:0] mode_ff, nxt_mode;
   // Last count of each timed phase.
   localparam logic [chc_pkg::CNT_W-1:0] CNT_LAST = chc_pkg::CNT_W'(chc_pkg::RESET_CYC - 1);
   localparam logic [chc_pkg::CNT_W-1:0] SETUP_LAST = chc_pkg::CNT_W'(chc_pkg::SETUP_CYC - 1);
   localparam logic [chc_pkg::CNT_W-1:0] STROBE_LAST = chc_pkg::CNT_W'(chc_pkg::STROBE_CYC - 1);

   function automatic logic agree(input logic [2:0] s, input logic old);
      agree = (s[1] == s[2]) ? s[2] : old;
   endfunction : agree

   always_comb begin
      nxt_rdy_sync = {rdy_sync_ff[1:0], i_card_ready};
      nxt_irq_sync = {irq_sync_ff[1:0], i_card_interrupt_request};
      nxt_drq_sync = {drq_sync_ff[1:0], i_dma_request_line};
      nxt_rdy = agree(rdy_sync_ff, rdy_ff);
      nxt_irq = agree(irq_sync_ff, irq_ff);
      nxt_drq = agree(drq_sync_ff, drq_ff);
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdy_sync_ff <= 3'h0;
         irq_sync_ff <= 3'h7;
         drq_sync_ff <= 3'h0;
         rdy_ff <= 1'b0;
         irq_ff <= 1'b1;
         drq_ff <= 1'b0;
      end else begin
         rdy_sync_ff <= nxt_rdy_sync;
         irq_sync_ff <= nxt_irq_sync;
         drq_sync_ff <= nxt_drq_sync;
         rdy_ff <= nxt_rdy;
         irq_ff <= nxt_irq;
         drq_ff <= nxt_drq;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_wr = wr_ff;
      nxt_attr = attr_ff;
      nxt_mode = mode_ff;
      nxt_done = 1'b0;
      case (state_ff)
         chc_pkg::CHC_ST_RESET: begin
            if (cnt_ff == CNT_LAST) begin
               nxt_state = chc_pkg::CHC_ST_WAITRDY;
            end else begin
               nxt_cnt = cnt_ff + chc_pkg::CNT_ONE;
            end
         end
         // RULE14 wait for ready.
         chc_pkg::CHC_ST_WAITRDY: begin
            if (rdy_ff) begin
               nxt_state = chc_pkg::CHC_ST_IDLE;
            end
         end
         chc_pkg::CHC_ST_IDLE: begin
            if (i_card_reset) begin
               nxt_state = chc_pkg::CHC_ST_RESET;
               nxt_cnt = chc_pkg::CNT_ZERO;
            // RULE20 RULE7 acknowledge request, strobe negated.
            end else if (i_dma_enable && mode_ff == chc_pkg::CHC_MODE_IDE && drq_ff
                         && !i_burst_stop) begin
               nxt_state = chc_pkg::CHC_ST_DMA;
            end else if (i_req_valid && rdy_ff) begin
               nxt_state = chc_pkg::CHC_ST_SETUP;
               nxt_cnt = chc_pkg::CNT_ZERO;
               nxt_wr = i_req_write;
               nxt_attr = i_req_attr;
            end
         end
         chc_pkg::CHC_ST_SETUP: begin
            if (cnt_ff == SETUP_LAST) begin
               nxt_state = chc_pkg::CHC_ST_STROBE;
               nxt_cnt = chc_pkg::CNT_ZERO;
            end else begin
               nxt_cnt = cnt_ff + chc_pkg::CNT_ONE;
            end
         end
         // RULE5 strobe released to clock data.
         chc_pkg::CHC_ST_STROBE: begin
            if (cnt_ff == STROBE_LAST) begin
               nxt_state = chc_pkg::CHC_ST_IDLE;
               nxt_done = 1'b1;
            end else begin
               nxt_cnt = cnt_ff + chc_pkg::CNT_ONE;
            end
         end
         // RULE8 stop ends burst.
         chc_pkg::CHC_ST_DMA: begin
            if (i_burst_stop || !drq_ff) begin
               nxt_state = chc_pkg::CHC_ST_IDLE;
            end
         end
         default: begin
            nxt_state = chc_pkg::CHC_ST_RESET;
         end
      endcase
      // RULE25 mode latched only during card reset.
      if (state_ff == chc_pkg::CHC_ST_RESET) begin
         nxt_mode = i_mode;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_ff <= chc_pkg::CHC_ST_RESET;
         cnt_ff <= chc_pkg::CNT_ZERO;
         wr_ff <= 1'b0;
         attr_ff <= 1'b0;
         done_ff <= 1'b0;
         mode_ff <= chc_pkg::CHC_MODE_MEM;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         wr_ff <= nxt_wr;
         attr_ff <= nxt_attr;
         done_ff <= nxt_done;
         mode_ff <= nxt_mode;
      end
   end

   logic strobing, is_ide, is_io, is_mem, in_dma;
   assign strobing = (state_ff == chc_pkg::CHC_ST_STROBE);
   assign in_dma = (state_ff == chc_pkg::CHC_ST_DMA);
   assign is_ide = (mode_ff == chc_pkg::CHC_MODE_IDE);
   assign is_io = (mode_ff == chc_pkg::CHC_MODE_IO);
   assign is_mem = !is_ide && !is_io;

   // RULE24 reset polarity per mode.
   assign o_card_reset_pin = (state_ff == chc_pkg::CHC_ST_RESET) ? !is_ide : is_ide;
   // RULE11 ground IDE select.
   assign o_ide_mode_select_n = !is_ide;
   // RULE1 RULE2 RULE3 role select drive.
   assign o_drive_role_select_n = is_ide ? 1'b0 : i_a25;
   assign o_drive_role_select_oe = is_ide ? i_role_master : 1'b1;
   // RULE4 RULE6 RULE7 write strobe, idle high in memory mode and before DMA.
   assign o_io_write_strobe_n = in_dma ? !i_burst_stop
                              : !(strobing && wr_ff && !is_mem);
   assign o_write_enable_n = !(strobing && wr_ff && is_mem);
   // RULE9 RULE10 output enable reads.
   assign o_output_enable_n = !(strobing && !wr_ff && (is_mem || attr_ff));
   // RULE18 RULE19 space select.
   assign o_space_select_n = is_io ? 1'b0 : !attr_ff;
   // RULE22 RULE23 acknowledge and chip selects.
   assign o_dma_acknowledge_n = !in_dma;
   assign o_taskfile_chip_select_n = !(is_ide && strobing && !attr_ff);
   assign o_control_block_chip_select_n = !(is_ide && strobing && attr_ff);
   // RULE12 RULE13 ready shown to user.
   assign o_card_busy = !rdy_ff;
   assign o_req_ready = (state_ff == chc_pkg::CHC_ST_IDLE) && rdy_ff;
   assign o_done = done_ff;
   // RULE16 RULE17 interrupt polarity.
   assign o_irq = is_ide ? irq_ff : !irq_ff;
   assign o_dma_active = in_dma;

   property p_no_cs_in_dma;
      @(posedge i_clk) disable iff (!i_reset_n)
      in_dma |-> (o_taskfile_chip_select_n && o_control_block_chip_select_n);
   endproperty
   a_no_cs_in_dma: assert property (p_no_cs_in_dma) else $error("chip select during DMA"); // RULE23

   property p_no_access_busy;
      @(posedge i_clk) disable iff (!i_reset_n)
      (state_ff == chc_pkg::CHC_ST_RESET || state_ff == chc_pkg::CHC_ST_WAITRDY)
         |-> o_output_enable_n && o_write_enable_n && o_io_write_strobe_n
             && o_taskfile_chip_select_n && o_control_block_chip_select_n;
   endproperty
   a_no_access_busy: assert property (p_no_access_busy) else $error("access while busy"); // RULE14

   sequence s_enter_dma;
      state_ff == chc_pkg::CHC_ST_IDLE ##1 in_dma;
   endsequence
   property p_iow_before_dma;
      @(posedge i_clk) disable iff (!i_reset_n)
      s_enter_dma |-> $past(o_io_write_strobe_n);
   endproperty
   a_iow_before_dma: assert property (p_iow_before_dma) else $error("write strobe low at burst"); // RULE7

   property p_mem_no_iow;
      @(posedge i_clk) disable iff (!i_reset_n)
      is_mem && !in_dma |-> o_io_write_strobe_n;
   endproperty
   a_mem_no_iow: assert property (p_mem_no_iow) else $error("io write in memory mode"); // RULE4

   property p_io_space_low;
      @(posedge i_clk) disable iff (!i_reset_n)
      is_io |-> !o_space_select_n;
   endproperty
   a_io_space_low: assert property (p_io_space_low) else $error("space select high in io"); // RULE19

   property p_dack_only_dma;
      @(posedge i_clk) disable iff (!i_reset_n)
      !o_dma_acknowledge_n |-> $past(drq_ff) || drq_ff;
   endproperty
   a_dack_only_dma: assert property (p_dack_only_dma) else $error("ack without request"); // RULE20

   property p_strobe_width;
      @(posedge i_clk) disable iff (!i_reset_n)
      $rose(strobing) |-> strobing [*2];
   endproperty
   a_strobe_width: assert property (p_strobe_width) else $error("strobe too short"); // RULE5

   property p_stop_ends;
      @(posedge i_clk) disable iff (!i_reset_n)
      in_dma && i_burst_stop |=> !in_dma;
   endproperty
   a_stop_ends: assert property (p_stop_ends) else $error("burst not stopped"); // RULE8
endmodule : chc_host
`default_nettype wire

/* File: testbench/chc_card_model.sv */
/*
 Behavioural model of the storage card seen from its parallel port pins.
 Assumes the host controller drives every control pin and a shared clock paces the busy time.
*/
`timescale 1ns/1ps
`default_nettype none
module chc_card_model #(
   parameter int BUSY_CYC = 8
) (
   input wire logic i_clk,
   input wire logic i_reset_pin,
   input wire logic i_ide_sel_n,
   input wire logic i_role_sel,
   input wire logic i_io_write_strobe_n,
   input wire logic i_oe_n,
   input wire logic i_dma_acknowledge_n,
   input wire logic i_io_cfg,
   input wire logic i_fire,
   input wire logic i_dma_want,
   output logic o_ready,
   output logic o_card_interrupt_request,
   output logic o_dma_request_line,
   output logic o_master,
   output logic o_burst,
   output var int o_writes,
   output var int o_reads
);
   int cnt = BUSY_CYC;
   logic ide = 1'b0;
   logic stopped = 1'b0;
   logic in_reset;
   logic raw_reset;
   logic armed = 1'b0;
   initial o_burst = 1'b0;
   initial o_writes = 0;
   initial o_reads = 0;
   assign raw_reset = !i_ide_sel_n ? !i_reset_pin : i_reset_pin;
   // reset held since power-up is ignored.
   assign in_reset = raw_reset && armed;
   assign o_ready = (cnt == 0) && !in_reset;
   assign o_master = ide && !i_role_sel;
   assign o_card_interrupt_request = ide ? i_fire : !i_fire;
   assign o_dma_request_line = ide && i_dma_want && !stopped;
   always @(posedge i_clk) begin
      if (raw_reset === 1'b0) begin
         armed <= 1'b1;
      end
      if (in_reset) begin
         ide <= !i_ide_sel_n;
         cnt <= BUSY_CYC;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
      if (o_burst && !i_io_write_strobe_n) begin
         o_burst <= 1'b0;
         stopped <= 1'b1;
      end else if (o_dma_request_line && !i_dma_acknowledge_n) begin
         o_burst <= 1'b1;
      end
      if (!i_dma_want) begin
         stopped <= 1'b0;
      end
   end
   always @(posedge i_io_write_strobe_n) begin
      if (o_ready && (ide || i_io_cfg) && !o_burst) begin
         o_writes <= o_writes + 1;
      end
   end
   always @(negedge i_oe_n) begin
      if (o_ready && !ide) begin
         o_reads <= o_reads + 1;
      end
   end
endmodule : chc_card_model
`default_nettype wire

/* File: testbench/card_host_control_signals_test.sv */
/*
 Self-checking bench for the card host controller with the card model on its pins.
 Assumes the controller's package and the card model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module card_host_control_signals_test;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic [1:0] mode = 2'b00;
   logic role = 1'b1, dma_en = 1'b0, crst = 1'b0, vld = 1'b0, wr = 1'b0, attr = 1'b0;
   logic stop = 1'b0, a25 = 1'b0, io_cfg = 1'b0, fire = 1'b0, want = 1'b0;
   logic rdy, done, irq, dact, c_rdy, c_irq, c_drq, rpin, ide_n, rs_n, rs_oe, io_write_strobe_n, oe_n;
   logic dack_n, master, burst, role_wire;
   int writes, reads, bad_count = 0, checks = 0;
   logic busy, we_n, reg_n, cs0_n, cs1_n, reg_seen = 1'b1;
   int we_cnt = 0, cs0_cnt = 0, cs1_cnt = 0, iow_cnt = 0;
   always @(negedge we_n) we_cnt++;
   always @(negedge cs0_n) cs0_cnt++;
   always @(negedge cs1_n) cs1_cnt++;
   always @(negedge io_write_strobe_n) iow_cnt++;
   always @(negedge oe_n or negedge we_n) reg_seen = reg_n;
   always #2.5 i_clk = !i_clk;
   assign role_wire = rs_oe ? rs_n : 1'b1;
   chc_host dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_mode(mode), .i_role_master(role),
      .i_dma_enable(dma_en), .i_card_reset(crst), .i_req_valid(vld), .i_req_write(wr),
      .i_req_attr(attr), .i_burst_stop(stop), .i_a25(a25), .o_req_ready(rdy), .o_done(done),
      .o_card_busy(busy), .o_irq(irq), .o_dma_active(dact), .i_card_ready(c_rdy),
      .i_card_interrupt_request(c_irq), .i_dma_request_line(c_drq), .o_card_reset_pin(rpin),
      .o_ide_mode_select_n(ide_n), .o_drive_role_select_n(rs_n), .o_drive_role_select_oe(rs_oe),
      .o_io_write_strobe_n(io_write_strobe_n), .o_output_enable_n(oe_n), .o_write_enable_n(we_n),
      .o_space_select_n(reg_n), .o_dma_acknowledge_n(dack_n), .o_taskfile_chip_select_n(cs0_n),
      .o_control_block_chip_select_n(cs1_n));
   chc_card_model card_u (.i_clk(i_clk), .i_reset_pin(rpin), .i_ide_sel_n(ide_n),
      .i_role_sel(role_wire), .i_io_write_strobe_n(io_write_strobe_n), .i_oe_n(oe_n), .i_dma_acknowledge_n(dack_n),
      .i_io_cfg(io_cfg), .i_fire(fire), .i_dma_want(want), .o_ready(c_rdy), .o_card_interrupt_request(c_irq),
      .o_dma_request_line(c_drq), .o_master(master), .o_burst(burst), .o_writes(writes), .o_reads(reads));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic wait_for(ref logic sig, input int lim, output int n);
      n = 0;
      while (sig !== 1'b1 && n < lim) begin
         @(posedge i_clk);
         #1;
         n++;
      end
   endtask : wait_for
   task automatic req(input logic w, input logic a);
      int n;
      wait_for(rdy, 600, n);
      wr = w;
      attr = a;
      vld = 1'b1;
      @(posedge i_clk);
      #1;
      vld = 1'b0;
      wait_for(done, 40, n);
      chk("done", 1, n < 40);
   endtask : req
   task automatic card_reset(input logic [1:0] m, input logic r);
      int n;
      mode = m;
      role = r;
      crst = 1'b1;
      @(posedge i_clk);
      #1;
      crst = 1'b0;
      repeat (8) @(posedge i_clk);
      #1;
      chk("busy in reset", 1, busy);
      wait_for(rdy, 600, n);
      chk("ready after card reset", 1, rdy);
   endtask : card_reset
   task automatic t_power;
      int n;
      wait_for(rdy, 600, n);
      chk("busy span", 1, n >= chc_pkg::RESET_CYC);
      chk("card busy", 0, busy);
      $display("test power done");
   endtask : t_power
   task automatic t_mem;
      int w0, r0, e0, i0;
      w0 = writes;
      r0 = reads;
      e0 = we_cnt;
      i0 = iow_cnt;
      req(1'b1, 1'b0);
      chk("mem io writes", w0, writes);
      chk("mem io strobes", i0, iow_cnt);
      chk("mem write enable", e0 + 1, we_cnt);
      chk("mem common space", 1, reg_seen);
      req(1'b0, 1'b1);
      chk("mem reads", r0 + 1, reads);
      chk("mem attribute space", 0, reg_seen);
      a25 = 1'b1;
      @(posedge i_clk);
      #1;
      chk("role select a25", 1, role_wire);
      a25 = 1'b0;
      $display("test memory done");
   endtask : t_mem
   task automatic t_io;
      int w0, r0;
      io_cfg = 1'b1;
      card_reset(2'b01, 1'b0);
      w0 = writes;
      r0 = reads;
      req(1'b1, 1'b0);
      chk("io writes", w0 + 1, writes);
      req(1'b0, 1'b1);
      chk("io config reads", r0 + 1, reads);
      chk("io space", 0, reg_seen);
      fire = 1'b1;
      repeat (6) @(posedge i_clk);
      #1;
      chk("io irq", 1, irq);
      fire = 1'b0;
      $display("test io done");
   endtask : t_io
   task automatic t_ide;
      int w0, n, c0, c1;
      card_reset(2'b10, 1'b1);
      chk("master", 1, master);
      chk("ide select", 0, ide_n);
      chk("dack idle", 1, dack_n);
      w0 = writes;
      c0 = cs0_cnt;
      c1 = cs1_cnt;
      req(1'b1, 1'b0);
      chk("ide writes", w0 + 1, writes);
      chk("taskfile select", c0 + 1, cs0_cnt);
      req(1'b1, 1'b1);
      chk("control select", c1 + 1, cs1_cnt);
      c0 = cs0_cnt + cs1_cnt;
      fire = 1'b1;
      repeat (6) @(posedge i_clk);
      #1;
      chk("ide irq", 1, irq);
      fire = 1'b0;
      dma_en = 1'b1;
      want = 1'b1;
      wait_for(burst, 30, n);
      chk("burst start", 1, burst & dact);
      stop = 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      chk("burst end", 0, burst);
      stop = 1'b0;
      want = 1'b0;
      repeat (4) @(posedge i_clk);
      #1;
      chk("dma idle", 0, dact);
      chk("dma chip selects", c0, cs0_cnt + cs1_cnt);
      card_reset(2'b10, 1'b0);
      chk("slave", 0, master);
      $display("test ide done");
   endtask : t_ide
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #200000;
      bad_count++;
      wrap_up();
   end
   initial begin
      repeat (20) @(posedge i_clk);
      #1;
      i_reset_n = 1'b1;
      t_power();
      t_mem();
      t_io();
      t_ide();
      wrap_up();
   end
endmodule : card_host_control_signals_test
`default_nettype wire
